// ==== common/scm_pkg.sv ====
// Constants shared by both ends of the serial command intake link.
// Assumes a single 40 MHz system clock on both ends.
package scm_pkg;
    localparam int         CLK_HZ         = 40_000_000;
    localparam int         BAUD           = 115_200;
    localparam int         BIT_CYC        = CLK_HZ / BAUD;
    localparam logic [15:0] BIT_LAST      = 16'(BIT_CYC - 1);
    localparam logic [15:0] BIT_HALF      = 16'(BIT_CYC / 2);
    localparam int         BUF_DEPTH      = 512;
    localparam logic [9:0] BUF_FULL       = 10'h200;
    localparam logic [9:0] XOFF_LVL       = 10'h180;
    localparam logic [9:0] XON_LVL        = 10'h080;
    localparam logic [6:0] MAX_CMD        = 7'h7f;
    localparam logic [1:0] ESC_LAST       = 2'h2;
    localparam int         READY_WAIT_MS  = 10;
    localparam int         READY_WAIT_CYC = CLK_HZ / 1000 * READY_WAIT_MS;
    localparam logic [7:0] CH_CR          = 8'h0d;
    localparam logic [7:0] CH_OK          = 8'h3e;
    localparam logic [7:0] CH_ERR         = 8'h21;
    localparam logic [7:0] CH_OVF         = 8'h5e;
    localparam logic [7:0] CH_LERR        = 8'h3f;
    localparam logic [7:0] CH_XON         = 8'h11;
    localparam logic [7:0] CH_XOFF        = 8'h13;
endpackage

// ==== common/scm_link_if.sv ====
// Serial link between host end and device end: one line each way, idle high.
// Assumes both ends share clk; the lines carry 8N1 frames.
`timescale 1ns/1ps
interface scm_link_if;
    logic h2d;
    logic d2h;
    modport dev  (input h2d, output d2h);
    modport host (output h2d, input d2h);
endinterface

// ==== logic/scm_dev.sv ====
// Device end: UART, 512-byte command queue, prompts, flow control, port switch.
// Assumes the execution engine drains cmd bytes and answers with done handshakes.
`timescale 1ns/1ps

module scm_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } scm_fifo_st_t;
    scm_fifo_st_t s, n;
    logic push, pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready  = s.cnt != (AW+1)'(D);
    assign out_valid = s.cnt != '0;
    assign out_data  = s.mem[s.rp];

    always_comb begin
        n    = s;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            n.mem[s.wp] = in_data;
            n.wp        = nxt(s.wp);
        end
        if (pop) begin
            n.rp = nxt(s.rp);
        end
        n.cnt = (AW+1)'(s.cnt + push - pop);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule // scm_fifo

module scm_uart_tx (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       valid,
    input  wire logic [7:0] data,
    output logic            ready,
    output logic            txd
);
    import scm_pkg::*;
    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
        logic [3:0]  bitn;
        logic [9:0]  sh;
    } scm_utx_st_t;
    scm_utx_st_t s, n;

    assign ready = !s.busy;
    assign txd   = s.sh[0];

    always_comb begin
        n = s;
        if (!s.busy) begin
            if (valid) begin
                n.sh   = {1'b1, data, 1'b0};
                n.busy = 1'b1;
                n.cnt  = '0;
                n.bitn = '0;
            end
        end else if (s.cnt == BIT_LAST) begin
            n.cnt  = '0;
            n.sh   = {1'b1, s.sh[9:1]};
            n.bitn = 4'(s.bitn + 1'b1);
            n.busy = s.bitn != 4'h9;
        end else begin
            n.cnt = 16'(s.cnt + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s    <= '0;
            s.sh <= 10'h3ff;
        end else begin
            s <= n;
        end
    end
endmodule // scm_uart_tx

module scm_uart_rx (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       rxd,
    output logic            valid,
    output logic [7:0]      data,
    output logic            ferr
);
    import scm_pkg::*;
    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        vld;
        logic        fe;
    } scm_urx_st_t;
    scm_urx_st_t s, n;

    assign valid = s.vld;
    assign data  = s.sh;
    assign ferr  = s.fe;

    always_comb begin
        n     = s;
        n.vld = 1'b0;
        if (!s.busy) begin
            if (!rxd) begin
                n.busy = 1'b1;
                n.cnt  = BIT_HALF;
                n.bitn = '0;
            end
        end else if (s.cnt != '0) begin
            n.cnt = 16'(s.cnt - 1'b1);
        end else begin
            n.cnt  = BIT_LAST;
            n.bitn = 4'(s.bitn + 1'b1);
            if (s.bitn == 4'h0) begin
                n.busy = !rxd;  // Glitch, not a start bit
            end else if (s.bitn != 4'h9) begin
                n.sh = {rxd, s.sh[7:1]};
            end else begin
                n.busy = 1'b0;
                n.vld  = 1'b1;
                n.fe   = !rxd;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule // scm_uart_rx

// Overview of operation
// - Link runs 115200 8N1 with XON/XOFF
// - No echo; responses end with single CR
// - Text command ends at carriage return
// - Binary command length from 0x80-based byte
// - Host never sends over 127 characters
// - Optional space before numeric argument accepted
// - 512-byte circular queue, strict arrival order
// - Prompt '>' on success, '!' on failure
// - Prompts transmit while commands still arrive
// - Lone CR is empty command, succeeds
// - Host probes with empty command, waits 10ms
// - XOFF near three quarters, XON near quarter
// - Flow-blind host keeps two commands outstanding
// - Byte into full queue: drop and flush
// - After flush send caret prompt then XON
// - Line error sends '?' prompt
// - Outgoing messages sent whole, never interleaved
// - Activity indicator while executing or looping
// - Three switch chars on other port switch
// - Switch character defaults to CR, programmable
// - Reset returns to stored prior control port
module scm_dev (
    input  wire logic       clk,
    input  wire logic       rstn,
    scm_link_if.dev         link,
    output logic            cmd_valid,
    output logic [7:0]      cmd_data,
    output logic            cmd_last,
    input  wire logic       cmd_ready,
    input  wire logic       done_valid,
    input  wire logic       done_ok,
    output logic            done_ready,
    input  wire logic       loop_running,
    input  wire logic       set_port_switch_char_cmd,
    input  wire logic [7:0] port_switch_char_in,
    input  wire logic       restore_prior_port_cmd,
    input  wire logic       ctrl_port_nv_in,
    output logic            ctrl_port_nv_out,
    input  wire logic       aux_rx_valid,
    input  wire logic [7:0] aux_rx_data,
    input  wire logic       aux_line_err,
    output logic            aux_tx_valid,
    output logic [7:0]      aux_tx_data,
    input  wire logic       aux_tx_ready,
    output logic            activity_indicator,
    output logic            ctrl_on_aux
);
    import scm_pkg::*;
    typedef struct packed {
        logic [8:0] wp;
        logic [8:0] rp;
        logic [9:0] cnt;
        logic [9:0] pend;
        logic       first;
        logic       bin;
        logic [6:0] rem;
        logic       xoff_q;
        logic       xon_r;
        logic       xoff_r;
        logic       ovf_r;
        logic       lerr_r;
        logic       sw_r;
        logic [1:0] esc;
        logic       esc4;
        logic       sel;
        logic       prior;
        logic       loaded;
        logic [7:0] swc;
        logic       rv;
        logic       busy;
        logic       act;
        logic       tx_act;
        logic       tx_cr;
        logic       tx_aux;
        logic [7:0] tx_ch;
    } scm_dev_st_t;
    scm_dev_st_t s, n;

    logic [8:0] mem [BUF_DEPTH];
    logic [8:0] rdat;
    logic       u_vld, u_ferr, utx_ready, f_in_ready, tx_ok;
    logic [7:0] u_data, cb, ob;
    logic       cv, cerr, ov, issue, push, wr, lst, flush;

    scm_uart_rx u_rx (.clk(clk), .rstn(rstn), .rxd(link.h2d),
                      .valid(u_vld), .data(u_data), .ferr(u_ferr));
    scm_uart_tx u_tx (.clk(clk), .rstn(rstn), .valid(s.tx_act && !s.tx_aux),
                      .data(s.tx_ch), .ready(utx_ready), .txd(link.d2h));
    // Small skid between the queue and the engine; the engine may stall it
    scm_fifo #(.W(9), .D(8)) u_cmdq (
        .clk(clk), .rstn(rstn), .in_valid(s.rv), .in_data(rdat),
        .in_ready(f_in_ready), .out_valid(cmd_valid),
        .out_data({cmd_last, cmd_data}), .out_ready(cmd_ready));

    assign aux_tx_valid       = s.tx_act && s.tx_aux;
    assign aux_tx_data        = s.tx_ch;
    assign ctrl_on_aux        = s.sel;
    assign ctrl_port_nv_out   = s.sel;
    assign activity_indicator = s.act;

    always_comb begin
        n          = s;
        cv         = s.sel ? aux_rx_valid : (u_vld && !u_ferr);
        cb         = s.sel ? aux_rx_data : u_data;
        cerr       = s.sel ? aux_line_err : (u_vld && u_ferr);
        ov         = s.sel ? u_vld : aux_rx_valid;
        ob         = s.sel ? u_data : aux_rx_data;
        issue      = s.cnt != '0 && s.pend != '0 && !s.rv && f_in_ready;
        push       = s.rv && f_in_ready;
        tx_ok      = s.tx_aux ? aux_tx_ready : utx_ready;
        done_ready = 1'b0;
        wr         = 1'b0;
        lst        = 1'b0;
        flush      = 1'b0;
        // One message at a time; a prompt and its CR leave back to back
        if (s.tx_act) begin
            if (tx_ok) begin
                if (s.tx_cr) begin
                    n.tx_ch = CH_CR;
                    n.tx_cr = 1'b0;
                end else begin
                    n.tx_act = 1'b0;
                end
            end
        end else begin
            n.tx_aux = s.sel;
            n.tx_act = 1'b1;
            n.tx_cr  = 1'b1;
            if (s.xoff_r) begin
                n.tx_ch  = CH_XOFF;
                n.tx_cr  = 1'b0;
                n.xoff_r = 1'b0;
            end else if (s.ovf_r) begin
                n.tx_ch = CH_OVF;
                n.ovf_r = 1'b0;
            end else if (s.lerr_r) begin
                n.tx_ch  = CH_LERR;
                n.lerr_r = 1'b0;
            end else if (s.sw_r) begin
                n.tx_ch = CH_OK;
                n.sw_r  = 1'b0;
            end else if (done_valid) begin
                done_ready = 1'b1;
                n.tx_ch    = done_ok ? CH_OK : CH_ERR;
                n.busy     = 1'b0;
            end else if (s.xon_r) begin
                n.tx_ch = CH_XON;
                n.tx_cr = 1'b0;
                n.xon_r = 1'b0;
            end else begin
                n.tx_act = 1'b0;
            end
        end
        if (cmd_valid && cmd_ready && cmd_last) begin
            n.busy = 1'b1;
        end
        n.act = s.busy || loop_running;
        if (!s.xoff_q && s.cnt >= XOFF_LVL) begin
            n.xoff_q = 1'b1;
            n.xoff_r = 1'b1;
        end else if (s.xoff_q && s.cnt <= XON_LVL) begin
            n.xoff_q = 1'b0;
            n.xon_r  = 1'b1;
        end
        if (issue) begin
            n.rp = 9'(s.rp + 1'b1);
            n.rv = 1'b1;
        end
        if (push) begin
            n.rv = 1'b0;
        end
        if (cerr) begin
            n.lerr_r = 1'b1;
        end else if (cv) begin
            n.esc4 = 1'b0;
            if (s.esc4 && cb == s.swc) begin
                n.sw_r = 1'b1;
            end else if (s.cnt == BUF_FULL) begin
                flush   = 1'b1;
                n.ovf_r = 1'b1;
                n.xon_r = 1'b1;
                n.xoff_q = 1'b0;
            end else begin
                // Bytes pass verbatim, so "p2" and "p 2" both reach the engine
                wr = 1'b1;
                if (s.first) begin
                    n.bin = cb[7];
                    n.rem = cb[6:0];
                    lst   = cb[7] ? (cb[6:0] == 7'h00) : (cb == CH_CR);
                end else if (s.bin) begin
                    lst   = s.rem == 7'h01;
                    n.rem = 7'(s.rem - 1'b1);
                end else begin
                    lst = cb == CH_CR;
                end
                n.first = lst;
                n.wp    = 9'(s.wp + 1'b1);
            end
        end
        n.cnt  = 10'(s.cnt + wr - issue);
        n.pend = 10'(s.pend + (wr && lst) - (push && rdat[8]));
        if (flush) begin
            n.rp    = s.wp;
            n.cnt   = '0;
            n.pend  = '0;
            n.rv    = 1'b0;
            n.first = 1'b1;
            n.bin   = 1'b0;
        end
        if (set_port_switch_char_cmd) begin
            n.swc = port_switch_char_in;
        end
        if (restore_prior_port_cmd) begin
            n.sel   = s.prior;
            n.prior = s.sel;
        end
        // Any byte on the idle port other than the switch char restarts the count
        if (ov) begin
            if (ob == s.swc) begin
                if (s.esc == ESC_LAST) begin
                    n.sel   = !s.sel;
                    n.prior = s.sel;
                    n.esc4  = 1'b1;
                    n.esc   = '0;
                end else begin
                    n.esc = 2'(s.esc + 1'b1);
                end
            end else begin
                n.esc = '0;
            end
        end
        if (!s.loaded) begin
            n.sel    = ctrl_port_nv_in;
            n.prior  = ctrl_port_nv_in;
            n.loaded = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[s.wp] <= {lst, cb};
        end
        if (issue) begin
            rdat <= mem[s.rp];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s       <= '0;
            s.swc   <= CH_CR;
            s.first <= 1'b1;
        end else begin
            s <= n;
        end
    end
endmodule // scm_dev

// ==== logic/scm_host.sv ====
// Host end: sends framed commands, probes readiness, honours flow control.
// Assumes scm_uart_rx and scm_uart_tx from the device file are compiled first.
`timescale 1ns/1ps
module scm_host #(
    parameter int WAIT_CYC = scm_pkg::READY_WAIT_CYC
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    scm_link_if.host        link,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       honour_flow,
    output logic            dev_ready,
    output logic            paused
);
    import scm_pkg::*;
    typedef struct packed {
        logic        rdy;
        logic        probe;
        logic [31:0] tmr;
        logic        xoff;
        logic [1:0]  outst;
        logic [6:0]  len;
        logic        rxv;
        logic [7:0]  rxd;
    } scm_host_st_t;
    scm_host_st_t s, n;
    logic       u_vld, u_ferr, utx_ready, utx_valid, gate, sent, prm;
    logic [7:0] u_data, utx_data;

    scm_uart_rx u_rx (.clk(clk), .rstn(rstn), .rxd(link.d2h),
                      .valid(u_vld), .data(u_data), .ferr(u_ferr));
    scm_uart_tx u_tx (.clk(clk), .rstn(rstn), .valid(utx_valid),
                      .data(utx_data), .ready(utx_ready), .txd(link.h2d));

    assign rx_valid  = s.rxv;
    assign rx_data   = s.rxd;
    assign dev_ready = s.rdy;
    assign paused    = !gate;

    always_comb begin
        n     = s;
        n.rxv = 1'b0;
        // A command may not run past 127 bytes; its last byte must end it
        gate = s.rdy && (honour_flow ? !s.xoff : s.outst != 2'h2)
               && !(s.len == 7'(MAX_CMD - 1'b1) && !tx_last);
        tx_ready  = gate && utx_ready;
        utx_valid = s.rdy ? (tx_valid && gate) : !s.probe;
        utx_data  = s.rdy ? tx_data : CH_CR;
        sent      = s.rdy && tx_valid && tx_ready;
        prm       = u_vld && !u_ferr && (u_data == CH_OK || u_data == CH_ERR);
        if (!s.rdy) begin
            if (!s.probe && utx_ready) begin
                n.probe = 1'b1;
                n.tmr   = '0;
            end else if (s.probe) begin
                n.tmr = s.tmr + 1'b1;
                if (s.tmr == 32'(WAIT_CYC - 1)) begin
                    n.probe = 1'b0;
                end
            end
            if (u_vld && u_data == CH_OK) begin
                n.rdy = 1'b1;
            end
        end
        if (sent) begin
            n.len = tx_last ? 7'h00 : 7'(s.len + 1'b1);
        end
        n.outst = 2'(s.outst + (sent && tx_last) - (prm && s.rdy && s.outst != 2'h0));
        if (u_vld && !u_ferr) begin
            if (u_data == CH_XOFF) begin
                n.xoff = 1'b1;
            end else if (u_data == CH_XON) begin
                n.xoff = 1'b0;
            end else begin
                n.rxv = 1'b1;
                n.rxd = u_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule // scm_host

// ==== tb/scm_link_props.sv ====
// Wire checker: bit timing and frame levels on both serial lines.
// Assumes both ends share clk and send 8N1 frames at BIT_CYC clocks a bit.
`timescale 1ns/1ps
module scm_link_props
    import scm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic h2d,
    input wire logic d2h
);
    localparam logic [15:0] STOP_MID = 16'(9 * BIT_CYC + BIT_CYC / 2);
    logic [1:0]  ln, prev_q, act_q;
    logic [15:0] pos_q [2];
    logic [15:0] run_q [2];
    assign ln = {h2d, d2h};
    // Frame position counts from the first low sample; it ends at mid stop bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 2'h3;
            act_q  <= 2'h0;
            pos_q  <= '{default: 16'h0};
            run_q  <= '{default: 16'hffff};
        end else begin
            for (int i = 0; i < 2; i++) begin
                prev_q[i] <= ln[i];
                if (ln[i] != prev_q[i]) begin
                    run_q[i] <= 16'h0;
                end else if (run_q[i] != 16'hffff) begin
                    run_q[i] <= run_q[i] + 16'h1;
                end
                if (!act_q[i] && prev_q[i] && !ln[i]) begin
                    act_q[i] <= 1'b1;
                    pos_q[i] <= 16'h1;
                end else if (act_q[i]) begin
                    pos_q[i] <= pos_q[i] + 16'h1;
                    act_q[i] <= (pos_q[i] != STOP_MID);
                end
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_start_d;
        !act_q[0] && prev_q[0] && !d2h;
    endsequence
    sequence s_start_h;
        !act_q[1] && prev_q[1] && !h2d;
    endsequence
    AST_D2H_START: assert property (s_start_d |-> ##173 !d2h)
        else $error("device line start bit not low at mid bit");
    AST_H2D_START: assert property (s_start_h |-> ##173 !h2d)
        else $error("host line start bit not low at mid bit");
    AST_D2H_STOP: assert property (pos_q[0] == STOP_MID |-> d2h)
        else $error("device line stop bit not high");
    AST_H2D_STOP: assert property (pos_q[1] == STOP_MID |-> h2d)
        else $error("host line stop bit not high");
    AST_D2H_EDGE: assert property (act_q[0] && d2h != prev_q[0] |-> pos_q[0] % BIT_CYC == 0)
        else $error("device line changed off a bit boundary");
    AST_H2D_EDGE: assert property (act_q[1] && h2d != prev_q[1] |-> pos_q[1] % BIT_CYC == 0)
        else $error("host line changed off a bit boundary");
    AST_D2H_RUN: assert property (d2h != prev_q[0] |-> run_q[0] >= BIT_LAST)
        else $error("device line level shorter than one bit");
    AST_H2D_RUN: assert property (h2d != prev_q[1] |-> run_q[1] >= BIT_LAST)
        else $error("host line level shorter than one bit");
endmodule // scm_link_props

// ==== tb/tb_serial_command_intake.sv ====
// Bench: host and device ends joined by scm_link_if, engine model and aux driver.
// Assumes the design files and scm_link_props are compiled first.
`timescale 1ns/1ps
module tb_serial_command_intake;
    import scm_pkg::*;
    typedef logic [7:0] scm_bq_t [$];
    logic clk, rstn, cmd_valid, cmd_last, cmd_ready, done_valid, done_ok, done_ready;
    logic loop_running, set_port_switch_char_cmd, restore_prior_port_cmd, ctrl_port_nv_in;
    logic ctrl_port_nv_out, aux_rx_valid, aux_line_err, aux_tx_valid, aux_tx_ready, took;
    logic activity_indicator, ctrl_on_aux, tx_valid, tx_last, tx_ready, rx_valid, paused;
    logic honour_flow, dev_ready, stall_q;
    logic [7:0] cmd_data, port_switch_char_in, aux_rx_data, aux_tx_data, tx_data, rx_data, wb;
    logic [8:0] exp_cmd [$];
    logic [7:0] exp_rx [$], all_rx [$], wire_q [$], aux_got [$];
    logic       ok_q [$];
    scm_bq_t    q;
    int         num_errors, checks_done, pend, k;
    scm_link_if link_if ();
    scm_dev scm_dev_inst (.link(link_if.dev), .*);
    scm_host #(.WAIT_CYC(20000)) scm_host_inst (.link(link_if.host), .*);
    scm_link_props scm_link_props_inst (.clk, .rstn, .h2d(link_if.h2d), .d2h(link_if.d2h));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic fail();
        num_errors++;
        wrap_up();
    endtask
    task automatic push_rx(input logic [7:0] b);
        exp_rx.push_back(b);
        all_rx.push_back(b);
    endtask
    // Valid stays up between bytes so it is never lowered and raised in one step
    task automatic send_cmd(input scm_bq_t c);
        ok_q.push_back(c[0] != 8'h78);
        push_rx(c[0] == 8'h78 ? CH_ERR : CH_OK);
        push_rx(CH_CR);
        foreach (c[i]) begin
            exp_cmd.push_back({i == c.size() - 1, c[i]});
            tx_valid = 1'b1;
            tx_data = c[i];
            tx_last = (i == c.size() - 1);
            for (k = 0; k < 40000; k++) begin
                @(posedge clk);
                if (tx_ready) break;
            end
            if (k == 40000) fail();
            @(negedge clk);
        end
        tx_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic aux_send(input logic [7:0] b);
        aux_rx_valid = 1'b1;
        aux_rx_data = b;
        @(negedge clk);
        aux_rx_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic aux_switch(input logic [7:0] ch);
        repeat (3) aux_send(ch);
        chk(ctrl_on_aux, 1'b1);
        chk(ctrl_port_nv_out, 1'b1);
        aux_send(ch);
        for (k = 0; k < 20000 && aux_got.size() < 2; k++) @(negedge clk);
        if (aux_got.size() < 2) fail();
        chk(aux_got.pop_front(), CH_OK);
        chk(aux_got.pop_front(), CH_CR);
        // Line error on the new control port must be reported there
        aux_line_err = 1'b1;
        @(negedge clk);
        aux_line_err = 1'b0;
        for (k = 0; k < 20000 && aux_got.size() < 2; k++) @(negedge clk);
        if (aux_got.size() < 2) fail();
        chk(aux_got.pop_front(), CH_LERR);
        chk(aux_got.pop_front(), CH_CR);
        restore_prior_port_cmd = 1'b1;
        @(negedge clk);
        restore_prior_port_cmd = 1'b0;
        @(negedge clk);
        chk(ctrl_on_aux, 1'b0);
    endtask
    always @(posedge clk) begin
        if (rstn && cmd_valid && cmd_ready) begin
            chk({cmd_last, cmd_data}, exp_cmd.size() ? exp_cmd.pop_front() : 9'h1ff);
            if (cmd_last) pend++;
        end
        if (rx_valid) chk({1'b0, rx_data}, exp_rx.size() ? exp_rx.pop_front() : 9'h1ff);
        if (aux_tx_valid && aux_tx_ready) aux_got.push_back(aux_tx_data);
        took = done_valid && done_ready;
        if (took) pend--;
        // A stalled byte must stay offered until the engine takes it
        if (stall_q) chk(cmd_valid, 1'b1);
        stall_q = rstn && cmd_valid && !cmd_ready;
    end
    // Engine model: random stalls on both byte ports, one done per finished command
    always @(negedge clk) begin
        cmd_ready = 1'($urandom_range(0, 1));
        aux_tx_ready = 1'($urandom_range(0, 1));
        if (!rstn) begin
            {done_valid, done_ok} = 2'h0;
        end else if (took) begin
            chk(activity_indicator, 1'b1);
            done_valid = 1'b0;
        end else if (!done_valid && pend > 0) begin
            done_valid = 1'b1;
            done_ok = ok_q.pop_front();
        end
    end
    initial forever begin
        @(negedge clk);
        if (rstn && link_if.d2h === 1'b0) begin
            repeat (173) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (347) @(negedge clk);
                wb[i] = link_if.d2h;
            end
            repeat (347) @(negedge clk);
            chk(link_if.d2h, 1'b1);
            wire_q.push_back(wb);
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail();
    end
    initial begin
        k = $urandom(25);
        {rstn, loop_running} = 2'h0;
        {set_port_switch_char_cmd, restore_prior_port_cmd, ctrl_port_nv_in} = 3'h0;
        {aux_rx_valid, aux_line_err, tx_valid, tx_last} = 4'h0;
        {aux_rx_data, tx_data} = '0;
        port_switch_char_in = CH_CR;
        honour_flow = 1'($urandom_range(0, 1));
        exp_cmd.push_back({1'b1, CH_CR});
        ok_q.push_back(1'b1);
        push_rx(CH_OK);
        push_rx(CH_CR);
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        for (k = 0; k < 40000 && !dev_ready; k++) @(negedge clk);
        chk(dev_ready, 1'b1);
        send_cmd({CH_CR});
        send_cmd({8'h70, 8'h20, 8'h32, CH_CR});
        send_cmd({8'h82, 8'h41, 8'h05});
        send_cmd({8'h80});
        send_cmd({8'h78, CH_CR});
        repeat (2) begin
            q = {};
            repeat ($urandom_range(1, 3)) q.push_back(8'($urandom_range(8'h30, 8'h7a)));
            q.push_back(CH_CR);
            send_cmd(q);
        end
        for (k = 0; k < 80000 && exp_rx.size() != 0; k++) @(negedge clk);
        if (exp_rx.size() != 0) fail();
        repeat (400) @(negedge clk);
        chk(9'(wire_q.size()), 9'(all_rx.size()));
        foreach (all_rx[i]) chk(wire_q[i], all_rx[i]);
        chk(link_if.d2h & link_if.h2d, 1'b1);
        loop_running = 1'b1;
        repeat (3) @(negedge clk);
        chk(activity_indicator, 1'b1);
        loop_running = 1'b0;
        repeat (3) @(negedge clk);
        chk(activity_indicator, 1'b0);
        aux_send(CH_CR);
        aux_send(CH_CR);
        aux_send(8'h41);
        chk(ctrl_on_aux, 1'b0);
        aux_switch(CH_CR);
        port_switch_char_in = 8'h1b;
        set_port_switch_char_cmd = 1'b1;
        @(negedge clk);
        set_port_switch_char_cmd = 1'b0;
        aux_switch(8'h1b);
        wrap_up();
    end
endmodule // tb_serial_command_intake
